// ### rtl/epp_defines.svh
// Register indices, field positions, mode codes and timing figures of the
// parallel port cycle engine. Included by the top module only.
// How it works
// R1: Newer-protocol read holds the bus transfer waiting until the byte is ready.
// R2: Handshake low at strobe: finish the read when the handshake rises.
// R3: Handshake high at start: wait for it low before touching marker or strobe.
// R4: Newer read floats the port bus, clears write marker, then strobes with direction in.
// R5: Peripheral drives the byte, then raises the handshake.
// R6: On handshake high the byte is captured and the strobe is released.
// R7: Captured byte is returned with the finishing ready answer.
// R8: Peripheral then floats the bus and drops the handshake.
// R9: Outside cycles the pins follow the control register and direction bit.
// R10: Older-protocol cycle over 10 us is aborted and status bit 0 set.
// R11: Software clears control bits 0, 1, 3 and sets direction before older cycles.
// R12: Older write waits while the handshake is low, finishes when high.
// R13: Older write drives the byte, then the matching data or address strobe.
// R14: Older write ends with ready answer, strobe released, byte held on bus.
// R15: In older mode the direction bit drives the write marker and bus float.
// R16: Older read waits for handshake high or time-out, whichever first.
// R17: Older read ends with ready answer and read byte, strobe released.
// R18: Peripheral interrupt passes through uninverted, rising-edge active.
// R19: Peripheral raises the handshake on completion, lowers it when ready.
// R20: Strobes and write marker are all active low.
// R21: Active-low peripheral reset output returns the peripheral to its start mode.
// R22: Address port at index 3, data ports at 4 to 7, enhanced modes only.
// R23: Newer-mode watchdog times 10 us to handshake high, aborts, sets status bit 0.
// R24: Watchdog is a clock-cycle counter whose limit derives from the clock rate.
// R25: Abort releases strobes, answers ready and returns to control-register pins.
`ifndef EPP_DEFINES_SVH
`define EPP_DEFINES_SVH

`define IDX_DATA      6'h00
`define IDX_STATUS    6'h01
`define IDX_CTRL      6'h02
`define IDX_EPP_ADDR  6'h03
`define IDX_EPP_D0    6'h04
`define IDX_EPP_D3    6'h07
`define IDX_MODE      6'h08

`define ST_TOUT       0
`define ST_FAULT      3
`define ST_ONLINE     4
`define ST_MEDIA      5
`define ST_ACK        6
`define ST_NBUSY      7

`define CT_STROBE     0
`define CT_LFEED      1
`define CT_INIT       2
`define CT_SELIN      3
`define CT_IRQE       4
`define CT_PCD        5
`define CTRL_RST      6'h00

`define MODE_SPP      2'h0
`define MODE_NEW      2'h1
`define MODE_OLD      2'h2

`define TOUT_NS       10000
`define CLK_NS        100
`define TOUT_CYC      (`TOUT_NS / `CLK_NS)

`endif

// ### rtl/epp_pkg.sv
// Types of the parallel port cycle engine: controller states and the
// complete register state of the top module.
// Assumes nothing beyond a SystemVerilog compiler.
package epp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WLOW  = 2'b01,
    ST_STRB  = 2'b10
  } fsm_t;

  typedef struct packed {
    fsm_t        fsm;
    logic [15:0] cnt;
    logic        cyc_wr;
    logic        cyc_addr;
    logic        cyc_old;
    logic [7:0]  data;
    logic [7:0]  addr;
    logic [5:0]  ctrl;
    logic [1:0]  mode;
    logic        tout;
    logic        irq_prev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        dstb_n;
    logic        astb_n;
    logic        wr_n;
    logic        dir;
    logic [7:0]  bus_o;
    logic        bus_oe_n;
    logic        strobe_n;
    logic        lfeed_n;
    logic        init_n;
    logic        selin_n;
    logic        irq;
  } state_t;

endpackage : epp_pkg

// ### rtl/epp_cycle_engine.sv
// Parallel port cycle engine: an APB slave whose enhanced-port accesses
// become interlocked byte cycles on the parallel port bus.
// Assumes one 10 MHz clock, APB master on the host side and an external
// enhanced-port peripheral whose inputs are synchronous to mclk.
`timescale 1ns/100ps
`include "epp_defines.svh"

module epp_cycle_engine #(
  parameter int TOUT_CYCLES = `TOUT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  port_bus_in,
  output logic [7:0]       port_bus_out,
  output logic             port_bus_oe_n,
  output logic             data_strobe_n,
  output logic             addr_strobe_n,
  output logic             write_cycle_marker_n,
  output logic             bus_direction_flag,
  output logic             strobe_n,
  output logic             line_feed_ctl_n,
  output logic             select_in_n,
  output logic             peripheral_reset_n,
  input  wire logic        peripheral_ready_handshake,
  input  wire logic        peripheral_irq,
  input  wire logic        fault_in_n,
  input  wire logic        media_exhausted,
  input  wire logic        device_online,
  output logic             irq_out
);
  import epp_pkg::*;

  // The watchdog counter is 16 bits wide and must run for at least one cycle.
  if (TOUT_CYCLES < 1 || TOUT_CYCLES > 65535) begin : g_tout_chk
    $error("TOUT_CYCLES must lie between 1 and 65535.");
  end

  localparam logic [15:0] TOUT_LIM = 16'(TOUT_CYCLES);

  state_t q;
  state_t d;

  logic [5:0] idx;
  logic       access;
  logic       is_epp;
  logic [7:0] status;

  assign idx    = paddr[7:2];
  assign access = psel & penable & ~q.pready & (q.fsm == ST_IDLE);
  assign is_epp = (idx >= `IDX_EPP_ADDR) && (idx <= `IDX_EPP_D3) && (q.mode != `MODE_SPP); // R22

  always_comb begin
    status = 8'h00;
    status[`ST_TOUT]   = q.tout;
    status[`ST_FAULT]  = fault_in_n;
    status[`ST_ONLINE] = device_online;
    status[`ST_MEDIA]  = media_exhausted;
    status[`ST_ACK]    = peripheral_irq;
    status[`ST_NBUSY]  = ~peripheral_ready_handshake;
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    d          = q;
    d.pready   = 1'b0; // R1
    d.pslverr  = 1'b0;
    d.irq_prev = peripheral_irq;

    case (q.fsm)
      ST_IDLE: begin
        d.cnt = 16'h0000;
        if (access && is_epp) begin
          d.cyc_wr   = pwrite;
          d.cyc_addr = (idx == `IDX_EPP_ADDR);
          d.cyc_old  = (q.mode == `MODE_OLD);
          if (pwrite) begin
            if (idx == `IDX_EPP_ADDR) begin
              d.addr = pwdata[7:0];
            end else begin
              d.data = pwdata[7:0]; // R14
            end
          end
          if (q.mode == `MODE_NEW && peripheral_ready_handshake) begin
            d.fsm = ST_WLOW; // R3
          end else begin
            d.fsm = ST_STRB; // R13
          end
        end else if (access) begin
          d.pready = 1'b1;
          d.prdata = 32'h0000_0000;
          case (idx)
            `IDX_DATA: begin
              if (pwrite) begin
                d.data  = pwdata[7:0];
                d.bus_o = pwdata[7:0]; // R9
              end
              d.prdata[7:0] = (q.ctrl[`CT_PCD] && q.mode != `MODE_SPP) ? port_bus_in : q.data;
            end
            `IDX_STATUS: begin
              d.prdata[7:0] = status;
            end
            `IDX_CTRL: begin
              if (pwrite) begin
                d.ctrl = pwdata[5:0];
              end
              d.prdata[5:0] = q.ctrl;
            end
            `IDX_MODE: begin
              if (pwrite) begin
                d.mode = pwdata[1:0];
              end
              d.prdata[1:0] = q.mode;
            end
            default: begin
              if (!(idx >= `IDX_EPP_ADDR && idx <= `IDX_EPP_D3)) begin
                d.pslverr = 1'b1;
              end else begin
                d.prdata[7:0] = (idx == `IDX_EPP_ADDR) ? q.addr : q.data;
              end
            end
          endcase
        end
      end
      ST_WLOW: begin
        d.cnt = q.cnt + 16'h0001; // R24
        if (!peripheral_ready_handshake) begin
          d.fsm = ST_STRB; // R3
        end else if (q.cnt >= TOUT_LIM) begin
          d.fsm    = ST_IDLE; // R23
          d.tout   = 1'b1;
          d.pready = 1'b1; // R25
          d.prdata = {24'h00_0000, port_bus_in};
        end
      end
      ST_STRB: begin
        d.cnt = q.cnt + 16'h0001; // R24
        if (peripheral_ready_handshake && q.cnt != 16'h0000) begin
          d.fsm    = ST_IDLE; // R2 R6 R12 R16
          d.pready = 1'b1; // R7 R14 R17
          d.prdata = 32'h0000_0000;
          if (!q.cyc_wr) begin
            d.prdata[7:0] = port_bus_in; // R6
            if (q.cyc_addr) begin
              d.addr = port_bus_in;
            end else begin
              d.data  = port_bus_in;
              d.bus_o = port_bus_in;
            end
          end
        end else if (q.cnt >= TOUT_LIM) begin
          d.fsm    = ST_IDLE; // R10 R23
          d.tout   = 1'b1;
          d.pready = 1'b1; // R25
          d.prdata = {24'h00_0000, port_bus_in};
        end
      end
      default: begin
        d.fsm = ST_IDLE;
      end
    endcase

    // Software clears the time-out flag by writing 1; a new time-out wins.
    if (access && pwrite && idx == `IDX_STATUS && pwdata[`ST_TOUT] &&
        !(q.fsm != ST_IDLE && d.tout && !q.tout)) begin
      d.tout = 1'b0;
    end

    // ****************************************************************
    // Pin drive, from the state being entered.
    // ****************************************************************
    d.strobe_n = ~d.ctrl[`CT_STROBE]; // R9
    d.lfeed_n  = ~d.ctrl[`CT_LFEED];
    d.selin_n  = ~d.ctrl[`CT_SELIN];
    d.init_n   = d.ctrl[`CT_INIT]; // R21
    // The bus latch keeps the last byte written, address or data, or the last data byte read, until the next cycle.
    d.irq      = peripheral_irq & d.ctrl[`CT_IRQE]; // R18
    if (d.fsm == ST_STRB) begin
      d.dstb_n = d.cyc_addr; // R20
      d.astb_n = ~d.cyc_addr; // R20
      if (d.cyc_old) begin
        d.wr_n     = d.ctrl[`CT_PCD]; // R15
        d.bus_oe_n = d.ctrl[`CT_PCD];
        d.dir      = d.ctrl[`CT_PCD];
      end else begin
        d.wr_n     = ~d.cyc_wr; // R4
        d.bus_oe_n = ~d.cyc_wr; // R4
        d.dir      = ~d.cyc_wr;
      end
      d.bus_o = (d.cyc_wr && d.cyc_addr) ? d.addr : d.data; // R13
    end else if (d.fsm == ST_WLOW) begin
      d.dstb_n   = 1'b1;
      d.astb_n   = 1'b1;
      d.wr_n     = q.wr_n;
      d.bus_oe_n = q.bus_oe_n;
      d.dir      = q.dir;
      d.bus_o    = q.bus_o;
    end else begin
      d.dstb_n   = ~d.ctrl[`CT_LFEED]; // R9 R25
      d.astb_n   = ~d.ctrl[`CT_SELIN];
      d.dir      = d.ctrl[`CT_PCD] && d.mode != `MODE_SPP;
      d.bus_oe_n = d.dir;
      if (d.mode == `MODE_OLD) begin
        d.wr_n = d.ctrl[`CT_PCD]; // R15
      end else begin
        d.wr_n = ~d.ctrl[`CT_STROBE];
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q          <= '0;
      q.fsm      <= ST_IDLE;
      q.ctrl     <= `CTRL_RST;
      q.mode     <= `MODE_SPP;
      q.dstb_n   <= 1'b1;
      q.astb_n   <= 1'b1;
      q.wr_n     <= 1'b1;
      q.strobe_n <= 1'b1;
      q.lfeed_n  <= 1'b1;
      q.selin_n  <= 1'b1;
      q.init_n   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign pready               = q.pready;
  assign prdata               = q.prdata;
  assign pslverr              = q.pslverr;
  assign port_bus_out         = q.bus_o;
  assign port_bus_oe_n        = q.bus_oe_n;
  assign data_strobe_n        = q.dstb_n;
  assign addr_strobe_n        = q.astb_n;
  assign write_cycle_marker_n = q.wr_n;
  assign bus_direction_flag   = q.dir;
  assign strobe_n             = q.strobe_n;
  assign line_feed_ctl_n      = q.lfeed_n;
  assign select_in_n          = q.selin_n;
  assign peripheral_reset_n   = q.init_n;
  assign irq_out              = q.irq;

endmodule : epp_cycle_engine

// ### dv/epp_periph_model.sv
// Peripheral on the far side of the parallel port bus.
// Assumes the engine's strobes and bus drive; the bench paces it by knobs.
`timescale 1ns/100ps
module epp_periph_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       data_strobe_n,
  input  wire logic       addr_strobe_n,
  input  wire logic       write_cycle_marker_n,
  input  wire logic [7:0] port_bus_out,
  input  wire logic       port_bus_oe_n,
  input  wire logic [3:0] delay,
  input  wire logic       mute,
  input  wire logic       hold_hi,
  input  wire logic [7:0] rd_byte,
  output logic      [7:0] port_bus_in,
  output logic            peripheral_ready_handshake,
  output logic      [7:0] got_byte
);
  // ****************************************
  // Handshake and bus drive
  // ****************************************
  logic [3:0] cnt_q;
  logic       hs_q;
  logic       drv_q;
  logic [7:0] last_q;
  wire        strb = !data_strobe_n || !addr_strobe_n;

  // An undriven bus shows the inverse of its last level.
  assign port_bus_in = !port_bus_oe_n ? port_bus_out : drv_q ? rd_byte : ~last_q;
  assign peripheral_ready_handshake = hold_hi | hs_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {cnt_q, hs_q, drv_q, last_q, got_byte} <= '0;
    end else begin
      last_q <= port_bus_in;
      if (!strb) begin
        {cnt_q, hs_q, drv_q} <= '0;
      end else if (mute) begin
        cnt_q <= '0;
      end else if (cnt_q != delay) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (write_cycle_marker_n && !drv_q) begin
        drv_q <= 1'b1;
      end else begin
        hs_q <= 1'b1;
        got_byte <= port_bus_in;
      end
    end
  end
endmodule : epp_periph_model

// ### dv/epp_cycle_engine_chk.sv
// Port assertions for the parallel port cycle engine.
// Assumes it is bound into epp_cycle_engine with idle strobes high.
`timescale 1ns/100ps
module epp_cycle_engine_chk #(
  parameter int TOUT_CYCLES = 100
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  port_bus_in,
  input wire logic [7:0]  port_bus_out,
  input wire logic        port_bus_oe_n,
  input wire logic        data_strobe_n,
  input wire logic        addr_strobe_n,
  input wire logic        write_cycle_marker_n,
  input wire logic        bus_direction_flag,
  input wire logic        peripheral_ready_handshake,
  input wire logic        peripheral_irq,
  input wire logic        irq_out
);
  // ****************************************
  // Cycle properties
  // ****************************************
  localparam int LIM = TOUT_CYCLES + 4;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire strb = !data_strobe_n || !addr_strobe_n;

  sequence strb_done;
    strb ##1 strb && peripheral_ready_handshake;
  endsequence

  a_ans_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ans_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_read_floats: assert property (strb && bus_direction_flag |-> port_bus_oe_n && write_cycle_marker_n)
    else $error("bus driven during a read strobe");
  a_write_drives: assert property (strb && !write_cycle_marker_n |-> !port_bus_oe_n)
    else $error("bus floated during a write strobe");
  a_strb_release: assert property (strb_done |=> !strb)
    else $error("strobe kept after handshake high");
  a_ready_after: assert property (strb_done |=> pready)
    else $error("no ready after handshake high");
  a_read_capture: assert property (strb_done ##0 bus_direction_flag |=> prdata == {24'h0, $past(port_bus_in)})
    else $error("read byte not captured");
  a_write_hold: assert property (strb_done ##0 !write_cycle_marker_n |=> $stable(port_bus_out) [*2])
    else $error("written byte not held");
  a_strb_bound: assert property ($fell(data_strobe_n) |-> ##[1:LIM] data_strobe_n)
    else $error("strobe outlived the watchdog");
  a_irq_source: assert property (irq_out |-> $past(peripheral_irq))
    else $error("interrupt without input");
endmodule : epp_cycle_engine_chk

bind epp_cycle_engine epp_cycle_engine_chk #(.TOUT_CYCLES(TOUT_CYCLES)) chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .port_bus_in(port_bus_in),
  .port_bus_out(port_bus_out), .port_bus_oe_n(port_bus_oe_n),
  .data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n),
  .write_cycle_marker_n(write_cycle_marker_n), .bus_direction_flag(bus_direction_flag),
  .peripheral_ready_handshake(peripheral_ready_handshake),
  .peripheral_irq(peripheral_irq), .irq_out(irq_out));

// ### dv/test_epp_cycle_engine.sv
// Self-checking bench for the parallel port cycle engine.
// Assumes the peripheral model and the bound checker under dv/.
`timescale 1ns/100ps
module test_epp_cycle_engine;
  import epp_pkg::*;
  localparam logic [7:0] A_ST = 8'h04, A_CTRL = 8'h08, A_ADDR = 8'h0c;
  localparam logic [7:0] A_D0 = 8'h10, A_MODE = 8'h20;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic        port_bus_oe_n, data_strobe_n, addr_strobe_n, write_cycle_marker_n;
  logic        bus_direction_flag, strobe_n, line_feed_ctl_n, select_in_n, irq_out;
  logic        peripheral_reset_n, peripheral_ready_handshake, peripheral_irq;
  logic        fault_in_n, media_exhausted, device_online, mute, hold_hi;
  logic [3:0]  delay;
  logic [7:0]  paddr, port_bus_in, port_bus_out, rd_byte, got_byte;
  logic [31:0] pwdata, prdata, rdat;
  int          err_total, check_count;

  epp_cycle_engine #(.TOUT_CYCLES(20)) dut_u (.*);
  epp_periph_model periph_u (.*);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("mismatch %s exp %h got %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // One APB transfer; two idle edges follow so registered pins settle.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 500);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 500) begin
      err_total++;
      final_report();
    end
    repeat (2) @(posedge mclk);
  endtask : xfer

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask : rd

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, peripheral_irq} = '0;
    {mute, hold_hi, delay, rd_byte, err_total, check_count} = '0;
    fault_in_n = 1'b0;
    media_exhausted = 1'b1;
    device_online = 1'b1;
    sys_rst = 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("strobes", 2'b11, {data_strobe_n, addr_strobe_n});
    chk("prst", 0, peripheral_reset_n);
    rd("unmapped", 8'hfc, 0);
    chk("slverr", 1, rerr);
    xfer(1'b1, A_CTRL, 32'h24);
    chk("idle_pins", 4'h8, {peripheral_reset_n, bus_direction_flag, 1'b0, port_bus_oe_n});
    rd("ctrl", A_CTRL, 32'h24);
    xfer(1'b1, A_CTRL, 32'h04);
    chk("dir_out", 0, bus_direction_flag);
    rd("status", A_ST, 32'hb0);
    mute <= 1'b1;
    xfer(1'b1, A_CTRL, 32'h0f);
    chk("ctl_pins", 6'h04, {strobe_n, line_feed_ctl_n, select_in_n,
                            peripheral_reset_n, data_strobe_n, addr_strobe_n});
    xfer(1'b1, A_CTRL, 32'h04);
    mute <= 1'b0;
    $display("test standard done");
    xfer(1'b1, A_MODE, 32'h1);
    for (int i = 3; i < 8; i++) begin
      delay <= 4'(i - 3);
      rd_byte <= 8'(8'h50 + i);
      rd("new_rd", 8'(i * 4), 32'(8'h50 + i));
    end
    rd_byte <= 8'h5a;
    hold_hi <= 1'b1;
    @(posedge mclk);
    fork
      rd("new_rd_hi", A_D0, 32'h5a);
      begin
        repeat (6) @(posedge mclk);
        chk("wait_low", 1, data_strobe_n);
        hold_hi <= 1'b0;
      end
    join
    mute <= 1'b1;
    xfer(1'b0, A_D0, 0);
    mute <= 1'b0;
    chk("abort_strb", 1, data_strobe_n);
    rd("new_tout", A_ST, 32'hb1);
    xfer(1'b1, A_ST, 32'h1);
    rd("tout_clr", A_ST, 32'hb0);
    $display("test newer done");
    xfer(1'b1, A_MODE, 32'h2);
    xfer(1'b1, A_CTRL, 32'h04);
    chk("mark_lo", 0, write_cycle_marker_n);
    delay <= 4'h2;
    xfer(1'b1, A_D0, 32'ha5);
    chk("wr_byte", 8'ha5, got_byte);
    chk("wr_hold", 8'ha5, port_bus_out);
    xfer(1'b1, A_ADDR, 32'h3c);
    chk("wr_addr", 8'h3c, got_byte);
    xfer(1'b1, A_CTRL, 32'h24);
    chk("mark_hi", 2'b11, {write_cycle_marker_n, port_bus_oe_n});
    rd_byte <= 8'hc3;
    rd("old_rd", A_D0 + 8'h4, 32'hc3);
    mute <= 1'b1;
    xfer(1'b0, A_ADDR, 0);
    mute <= 1'b0;
    rd("old_tout", A_ST, 32'hb1);
    xfer(1'b1, A_ST, 32'h1);
    $display("test older done");
    xfer(1'b1, A_CTRL, 32'h34);
    peripheral_irq <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("irq", 1, irq_out);
    rd("st_irq", A_ST, 32'hf0);
    peripheral_irq <= 1'b0;
    $display("test interrupt done");
    final_report();
  end
endmodule : test_epp_cycle_engine
